// >>> hdl/spcr_cfg.svh
// constants of the serial port configuration register bank
// assumes a 13-bit register address space and 8-bit registers
`ifndef SPCR_CFG_SVH
`define SPCR_CFG_SVH
`define SPCR_A_PORT_CFG 13'h000
`define SPCR_A_VARIANT_ID 13'h003
`define SPCR_A_RB_SEL 13'h004
`define SPCR_A_PDS 13'h230
`define SPCR_A_UNUSED 13'h231
`define SPCR_A_COMMIT 13'h232
`define SPCR_RST_PORT_CFG 8'h18
`define SPCR_RST_RB_SEL 8'h00
`define SPCR_RST_PDS 8'h00
`define SPCR_CFG_LONG_INSTR 3
`define SPCR_CFG_SOFT_RESET 2
`define SPCR_CFG_LSB_FIRST 1
`define SPCR_CFG_SPLIT_PIN_MODE 0
`define SPCR_RB_ACTIVE 0
`define SPCR_COMMIT_BIT 0
`define SPCR_LONG_BITS 5'h10
`define SPCR_SHORT_BITS 5'h08
`define SPCR_LONG_RD 15
`define SPCR_SHORT_RD 7
`define SPCR_SYNC_CS 0
`define SPCR_SYNC_SCLK 1
`define SPCR_SYNC_DIN 2
`endif

// >>> hdl/spcr_pkg.sv
// types of the serial port configuration register bank
// assumes spcr_cfg.svh supplies all numeric constants
package spcr_pkg;
  typedef enum logic [1:0] {ph_idle, ph_instr, ph_data} spcr_phase_e;

  typedef struct packed {
    logic data_o;
    logic data_oe;
    logic serial_read_out_pin;
    logic serial_read_out_pin_oe;
  } spcr_pins_s;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_d;
    spcr_phase_e phase;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [2:0] bit_i;
    logic rd;
    logic [12:0] addr;
    logic [7:0] tx;
    logic [7:0] cfg;
    logic [7:0] rb;
    logic [7:0] pds_buf;
    logic [7:0] pds_act;
    logic upd;
    spcr_pins_s pins;
  } spcr_state_s;
endpackage

// >>> hdl/spcr_regs.sv
// serial control port slave with configuration, id, readback and commit registers
// assumes sclk, cs_n and data_i are asynchronous pins and sclk is well below clk/4
//
// Summary of operation
// - instruction-length bit zero means an 8-bit instruction and one a 16-bit one, reset one.
// - soft reset bit 2 set returns the readback select, pds and commit registers to their defaults.
// - the soft reset bit stays set until the host writes it to zero, which ends the reset.
// - bit-order zero (reset) shifts msb first and steps the address down per byte.
// - bit-order one shifts lsb first and steps the address up per byte.
// - split-pin mode zero (reset) uses the data pin both ways and floats the read-out pin.
// - split-pin mode one drives read data on the read-out pin, write data on the data pin.
// - address 0x003 is a read-only 8-bit variant code fixed for this part.
// - readback select at 0x004 returns buffer registers at zero (reset), active ones at one.
// - the commit bit at 0x232 resets to zero and clears itself after a write of one.
// - bit ranges of a field are written high:low in brackets, as in [5:2].
`include "spcr_cfg.svh"

module spcr_regs
  import spcr_pkg::*;
#(
  parameter logic [7:0] VARIANT_ID = 8'h5a // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_i,
  output spcr_pins_s pins,
  output logic [7:0] pds_active
);

  localparam spcr_state_s ST_RST = '{
    sync1: 3'h1, sync2: 3'h1, sclk_d: 1'b0, phase: ph_idle, sh: 16'h0000,
    cnt: 5'h00, bit_i: 3'h0, rd: 1'b0, addr: 13'h0000, tx: 8'h00,
    cfg: `SPCR_RST_PORT_CFG, rb: `SPCR_RST_RB_SEL, pds_buf: `SPCR_RST_PDS,
    pds_act: `SPCR_RST_PDS, upd: 1'b0, pins: 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // bit reversal, used for lsb-first instructions and data

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      o[i] = v[7 - i];
    end
    return o;
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    return {rev8(v[7:0]), rev8(v[15:8])};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  spcr_state_s r;
  spcr_state_s r_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic lsb;
  logic [15:0] shn;
  logic [15:0] ins;
  logic [7:0] ins8;
  logic [4:0] ins_len;
  logic [7:0] rd_val;
  logic [7:0] tx_v;
  logic out_bit;
  logic wr_en;
  logic [12:0] wr_a;
  logic [7:0] wr_d;
  logic byte_done;

  // edges from the second sync stage only
  assign sclk_rise = r.sync2[`SPCR_SYNC_SCLK] & ~r.sclk_d;
  assign sclk_fall = ~r.sync2[`SPCR_SYNC_SCLK] & r.sclk_d;
  assign lsb = r.cfg[`SPCR_CFG_LSB_FIRST];
  assign shn = {r.sh[14:0], r.sync2[`SPCR_SYNC_DIN]};

  always_comb begin
    r_nxt = r;
    wr_en = 1'b0;
    wr_a = r.addr;
    wr_d = 8'h00;
    byte_done = 1'b0;
    tx_v = 8'h00;
    out_bit = 1'b0;
    r_nxt.sync1 = {data_i, sclk, cs_n};
    r_nxt.sync2 = r.sync1;
    r_nxt.sclk_d = r.sync2[`SPCR_SYNC_SCLK];

    ins = lsb ? rev16(shn) : shn;
    ins8 = lsb ? rev8(shn[7:0]) : shn[7:0];
    ins_len = r.cfg[`SPCR_CFG_LONG_INSTR] ? `SPCR_LONG_BITS : `SPCR_SHORT_BITS;

    // readback mux; only the pds register has a separate active copy
    case (r.addr)
      `SPCR_A_PORT_CFG: rd_val = r.cfg;
      `SPCR_A_VARIANT_ID: rd_val = VARIANT_ID;
      `SPCR_A_RB_SEL: rd_val = r.rb;
      `SPCR_A_PDS: rd_val = r.rb[`SPCR_RB_ACTIVE] ? r.pds_act : r.pds_buf;
      `SPCR_A_COMMIT: rd_val = {7'h00, r.upd};
      default: rd_val = 8'h00;
    endcase

    if (r.sync2[`SPCR_SYNC_CS]) begin
      r_nxt.phase = ph_idle;
      r_nxt.cnt = 5'h00;
      r_nxt.bit_i = 3'h0;
      r_nxt.pins.data_oe = 1'b0;
      r_nxt.pins.serial_read_out_pin_oe = 1'b0;
    end else begin
      unique case (r.phase)
        ph_idle, ph_instr: begin
          r_nxt.phase = ph_instr;
          if (sclk_rise) begin
            r_nxt.sh = shn;
            r_nxt.cnt = 5'(r.cnt + 5'h01);
            if (5'(r.cnt + 5'h01) == ins_len) begin
              r_nxt.phase = ph_data;
              r_nxt.bit_i = 3'h0;
              if (r.cfg[`SPCR_CFG_LONG_INSTR]) begin
                r_nxt.rd = ins[`SPCR_LONG_RD];
                r_nxt.addr = ins[12:0];
              end else begin
                r_nxt.rd = ins8[`SPCR_SHORT_RD];
                r_nxt.addr = {8'h00, ins8[4:0]};
              end
            end
          end
        end
        ph_data: begin
          if (sclk_rise) begin
            r_nxt.sh = shn;
            r_nxt.bit_i = 3'(r.bit_i + 3'h1);
            if (r.bit_i == 3'h7) begin
              byte_done = 1'b1;
              wr_en = ~r.rd;
              wr_d = lsb ? rev8(shn[7:0]) : shn[7:0];
              r_nxt.addr = lsb ? 13'(r.addr + 13'h0001) : 13'(r.addr - 13'h0001);
            end
          end
          if (sclk_fall && r.rd) begin
            // a new byte is fetched on the falling edge before its first bit
            tx_v = (r.bit_i == 3'h0) ? (lsb ? rev8(rd_val) : rd_val) : r.tx;
            out_bit = tx_v[7];
            r_nxt.tx = {tx_v[6:0], 1'b0};
            if (r.cfg[`SPCR_CFG_SPLIT_PIN_MODE]) begin
              r_nxt.pins.serial_read_out_pin = out_bit;
              r_nxt.pins.serial_read_out_pin_oe = 1'b1;
              r_nxt.pins.data_oe = 1'b0;
            end else begin
              r_nxt.pins.data_o = out_bit;
              r_nxt.pins.data_oe = 1'b1;
              r_nxt.pins.serial_read_out_pin_oe = 1'b0;
            end
          end
        end
      endcase
    end

    // commit first so a fresh write of the commit bit still lands
    if (r.upd) begin
      r_nxt.pds_act = r.pds_buf;
      r_nxt.upd = 1'b0;
    end

    if (wr_en) begin
      case (wr_a)
        `SPCR_A_PORT_CFG: r_nxt.cfg = wr_d;
        `SPCR_A_RB_SEL: r_nxt.rb = {7'h00, wr_d[`SPCR_RB_ACTIVE]};
        `SPCR_A_PDS: r_nxt.pds_buf = wr_d;
        `SPCR_A_COMMIT: r_nxt.upd = wr_d[`SPCR_COMMIT_BIT];
        default: ;
      endcase
    end

    // held in reset while the bit stands; the port config keeps it so the host can clear it
    if (r.cfg[`SPCR_CFG_SOFT_RESET]) begin
      r_nxt.rb = `SPCR_RST_RB_SEL;
      r_nxt.pds_buf = `SPCR_RST_PDS;
      r_nxt.pds_act = `SPCR_RST_PDS;
      r_nxt.upd = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= ST_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign pins = r.pins;
  assign pds_active = r.pds_act;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  commit_clear_a: assert property (
    r.upd |=> !r.upd || $past(wr_en && wr_a == `SPCR_A_COMMIT))
    else $error("commit bit did not clear itself");

  commit_copy_a: assert property (
    r.upd && !r.cfg[`SPCR_CFG_SOFT_RESET] |=> r.pds_act == $past(r.pds_buf))
    else $error("buffered value not committed");

  soft_reset_a: assert property (
    r.cfg[`SPCR_CFG_SOFT_RESET] |=> r.rb == `SPCR_RST_RB_SEL && r.pds_act == `SPCR_RST_PDS
      && r.pds_buf == `SPCR_RST_PDS && !r.upd)
    else $error("soft reset left a register off its default");

  soft_hold_a: assert property (
    r.cfg[`SPCR_CFG_SOFT_RESET] && !(wr_en && wr_a == `SPCR_A_PORT_CFG)
      |=> r.cfg[`SPCR_CFG_SOFT_RESET])
    else $error("soft reset bit cleared without a write");

  addr_down_a: assert property (
    byte_done && !lsb |=> r.addr == 13'($past(r.addr) - 13'h0001))
    else $error("msb-first address did not step down");

  addr_up_a: assert property (
    byte_done && lsb |=> r.addr == 13'($past(r.addr) + 13'h0001))
    else $error("lsb-first address did not step up");

  shared_pin_a: assert property (
    r.pins.serial_read_out_pin_oe |-> $past(r.cfg[`SPCR_CFG_SPLIT_PIN_MODE]))
    else $error("read-out pin driven in shared mode");

  split_pin_a: assert property (
    r.pins.data_oe |-> !$past(r.cfg[`SPCR_CFG_SPLIT_PIN_MODE]) && $past(r.rd))
    else $error("data pin driven in split mode or on a write");

  instr_len_a: assert property (
    r.phase == ph_instr && sclk_rise && !r.sync2[`SPCR_SYNC_CS]
      && r.cnt == 5'(ins_len - 5'h01) |=> r.phase == ph_data)
    else $error("instruction length not honoured");

  oe_release_a: assert property (
    r.sync2[`SPCR_SYNC_CS] |=> !r.pins.data_oe && !r.pins.serial_read_out_pin_oe)
    else $error("pin still driven after deselect");

  oe_exclusive_a: assert property (
    !(r.pins.data_oe && r.pins.serial_read_out_pin_oe))
    else $error("both data pins driven at once");

  data_oe_rise_a: assert property (
    $rose(r.pins.data_oe) |-> $past(r.rd) && $past(r.phase) == ph_data)
    else $error("data pin driven outside a read");

  read_out_rise_a: assert property (
    $rose(r.pins.serial_read_out_pin_oe) |-> $past(r.rd) && $past(r.phase) == ph_data)
    else $error("read-out pin driven outside a read");

  act_hold_a: assert property (
    !r.upd && !r.cfg[`SPCR_CFG_SOFT_RESET] |=> $stable(r.pds_act))
    else $error("active copy changed without a commit");

  rb_bits_a: assert property (
    r.rb[7:1] == 7'h00)
    else $error("readback select holds more than one bit");

  commit_set_a: assert property (
    wr_en && wr_a == `SPCR_A_COMMIT && wr_d[`SPCR_COMMIT_BIT]
      && !r.cfg[`SPCR_CFG_SOFT_RESET] |=> r.upd)
    else $error("write of one did not set the commit bit");

  cfg_write_a: assert property (
    wr_en && wr_a == `SPCR_A_PORT_CFG |=> r.cfg == $past(wr_d))
    else $error("port config write lost");

  msb_first_out_a: assert property (
    sclk_fall && r.rd && r.phase == ph_data && !r.sync2[`SPCR_SYNC_CS] && r.bit_i == 3'h0
      && !lsb && r.cfg[`SPCR_CFG_SPLIT_PIN_MODE]
      |=> r.pins.serial_read_out_pin == $past(rd_val[7]))
    else $error("msb-first byte did not start with bit 7");

  lsb_first_out_a: assert property (
    sclk_fall && r.rd && r.phase == ph_data && !r.sync2[`SPCR_SYNC_CS] && r.bit_i == 3'h0
      && lsb && !r.cfg[`SPCR_CFG_SPLIT_PIN_MODE]
      |=> r.pins.data_o == $past(rd_val[0]))
    else $error("lsb-first byte did not start with bit 0");

  idle_restart_a: assert property (
    r.sync2[`SPCR_SYNC_CS] |=> r.phase == ph_idle && r.cnt == 5'h00 && r.bit_i == 3'h0)
    else $error("frame state not cleared on deselect");

  addr_hold_a: assert property (
    r.phase == ph_data && !byte_done && !r.sync2[`SPCR_SYNC_CS] |=> $stable(r.addr))
    else $error("address moved inside a byte");

  bit_step_a: assert property (
    r.phase == ph_data && sclk_rise && !r.sync2[`SPCR_SYNC_CS]
      |=> r.bit_i == 3'($past(r.bit_i) + 3'h1))
    else $error("bit counter skipped a data bit");

endmodule

// >>> verif/spcr_host.sv
// host model driving the serial control port pins
// assumes the bench calls xfer between frames only
module spcr_host
  import spcr_pkg::*;
(
  input wire logic clk,
  input spcr_pins_s pins,
  output logic sclk,
  output logic cs_n,
  output logic data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lsb = 1'b0, split = 1'b0, hd = 1'b0, hdrv = 1'b1, hz = 1'b0;
  logic lng = 1'b1;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  ////////////////////////////////////////
  // released line toggles, so a stale bit never reads as valid
  always @(posedge clk) hz <= ~hz;
  assign data_i = pins.data_oe ? pins.data_o : (hdrv ? hd : hz);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [15:0] wd,
    input int nb, output logic [15:0] rv);
    logic [15:0] ins;
    int ni, p, j;
    ins = lng ? {rd, 2'b00, a} : {8'h00, rd, 2'b00, a[4:0]};
    ni = lng ? 16 : 8;
    rv = 16'h0000;
    cs_n <= 1'b0;
    tick(6);
    for (int i = 0; i < ni + 8 * nb; i++) begin
      j = i - ni;
      if (i < ni) p = lsb ? i : ni - 1 - i;
      else p = 8 * (1 - j / 8) + (lsb ? j % 8 : 7 - j % 8);
      hdrv <= !(rd && i >= ni);
      if (i < ni) hd <= ins[p];
      else if (!rd) hd <= wd[p];
      sclk <= 1'b0;
      tick(6);
      // only the selected pin may drive; anything else reads unknown
      if (rd && i >= ni) rv[p] = split ?
        (pins.serial_read_out_pin_oe && !pins.data_oe ? pins.serial_read_out_pin : 1'bx) :
        (pins.data_oe && !pins.serial_read_out_pin_oe ? pins.data_o : 1'bx);
      sclk <= 1'b1;
      tick(6);
    end
    sclk <= 1'b0;
    hdrv <= 1'b1;
    tick(6);
    cs_n <= 1'b1;
    tick(8);
  endtask
endmodule

// >>> verif/spcr_regs_tb_top.sv
// self-checking bench of the serial port register bank
// assumes spcr_host owns the pins; expectations come from local functions
`include "spcr_cfg.svh"
module spcr_regs_tb_top
  import spcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VID = 8'h3c; // arbitrary value
  logic clk = 1'b0, rst = 1'b1, sclk, cs_n, data_i;
  spcr_pins_s pins;
  logic [7:0] pds_active, act, r;
  logic [15:0] rv;
  int seed = 77, bad_count = 0, check_count = 0;
  always #5 clk = ~clk;
  spcr_regs #(.VARIANT_ID(VID)) uut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .data_i(data_i), .pins(pins), .pds_active(pds_active));
  spcr_host host (.clk(clk), .pins(pins), .sclk(sclk), .cs_n(cs_n), .data_i(data_i));
  ////////////////////////////////////////
  function automatic logic [7:0] cfgb(input logic [3:0] n);
    return {n[0], n[1], n[2], n[3], n};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, {d, 8'h00}, 1, rv);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 16'h0000, 1, rv);
    chk($sformatf("reg %h", a), e, rv[15:8]);
  endtask
  task automatic close_out();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #400000; // about twice the expected run
    bad_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`SPCR_A_PORT_CFG, cfgb(4'h8));
    rd(`SPCR_A_VARIANT_ID, VID);
    rd(`SPCR_A_RB_SEL, 8'h00);
    rd(`SPCR_A_COMMIT, 8'h00);
    wr(`SPCR_A_VARIANT_ID, ~VID);
    rd(`SPCR_A_VARIANT_ID, VID);
    rd(13'h100, 8'h00);
    host.xfer(1'b1, `SPCR_A_RB_SEL, 16'h0000, 2, rv);
    chk("dec first", 8'h00, rv[15:8]);
    chk("dec second", VID, rv[7:0]);
    $display("test reset done");
    act = 8'h00;
    for (int k = 0; k < 4; k++) begin
      r = 8'($random(seed)) & 8'h07; // reserved bits kept clear
      wr(`SPCR_A_PDS, r);
      chk("pds held", act, pds_active);
      wr(`SPCR_A_RB_SEL, 8'h01);
      rd(`SPCR_A_PDS, act);
      wr(`SPCR_A_RB_SEL, 8'h00);
      rd(`SPCR_A_PDS, r);
      wr(`SPCR_A_COMMIT, 8'h01);
      act = r;
      chk("pds commit", act, pds_active);
      rd(`SPCR_A_COMMIT, 8'h00);
    end
    $display("test commit done");
    wr(`SPCR_A_PORT_CFG, cfgb(4'ha));
    host.lsb = 1'b1;
    rd(`SPCR_A_PORT_CFG, cfgb(4'ha));
    wr(`SPCR_A_RB_SEL, 8'h01);
    host.xfer(1'b1, `SPCR_A_VARIANT_ID, 16'h0000, 2, rv);
    chk("inc first", VID, rv[15:8]);
    chk("inc second", 8'h01, rv[7:0]);
    wr(`SPCR_A_PORT_CFG, cfgb(4'h9));
    host.lsb = 1'b0;
    host.split = 1'b1;
    rd(`SPCR_A_VARIANT_ID, VID);
    wr(`SPCR_A_PORT_CFG, cfgb(4'h1));
    host.lng = 1'b0;
    rd(`SPCR_A_VARIANT_ID, VID);
    wr(`SPCR_A_PORT_CFG, cfgb(4'h8));
    host.lng = 1'b1;
    host.split = 1'b0;
    rd(`SPCR_A_PORT_CFG, cfgb(4'h8));
    $display("test modes done");
    r = (8'($random(seed)) & 8'h07) | 8'h01;
    wr(`SPCR_A_PDS, r);
    wr(`SPCR_A_COMMIT, 8'h01);
    wr(`SPCR_A_PORT_CFG, cfgb(4'hc));
    rd(`SPCR_A_PORT_CFG, cfgb(4'hc));
    chk("pds soft", 8'h00, pds_active);
    rd(`SPCR_A_RB_SEL, 8'h00);
    wr(`SPCR_A_PDS, r);
    wr(`SPCR_A_PORT_CFG, cfgb(4'h8));
    rd(`SPCR_A_PDS, 8'h00);
    rd(`SPCR_A_PORT_CFG, cfgb(4'h8));
    $display("test soft reset done");
    close_out();
  end
endmodule
